// >>> src/adc_ctrl_map.vh
// Register addresses, field positions, reset values and timing counts for the
// extended-control register bank. Assumes inclusion by bare name.
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

`define ADDR_MAIN_CFG     4'h0
`define ADDR_RSVD_KEEP    4'h1
`define ADDR_OFFSET_TRIM  4'h2
`define ADDR_SCALE_TRIM   4'h3
`define ADDR_SEQ_CTRL     4'h4
`define ADDR_TRIM_VALUES  4'h5
`define ADDR_BIAS_TUNE    4'h6

`define RST_MAIN_CFG      16'h2000
`define RST_RSVD_KEEP     16'h2907
`define RST_OFFSET_TRIM   16'h0000
`define RST_SCALE_TRIM    16'h4000
`define RST_SEQ_CTRL      16'h0B4B
`define RST_TRIM_VALUES   16'h0000
`define RST_BIAS_TUNE     16'h1C2E
`define RST_OFFSET_FIELD  12'h000
`define RST_SCALE_FIELD   15'h4000

`define BIT_CAL_START     15
`define BIT_CLK_PHASE     14
`define BIT_SWING         13
`define BIT_PATTERN       12
`define BIT_PD_I          11
`define BIT_PD_Q          10
`define BIT_SLOW_CLK      8
`define MODE_HI           7
`define MODE_LO           5
`define BIT_DE_ENABLE     7
`define BIT_DE_INPUT      6
`define BIT_DE_TIE        5
`define BIT_SIGNED        4
`define BIT_STAMP         3
`define BIT_SINGLE_RATE   2
`define BIT_OFS_POL       12
`define OFS_SIZE_HI       11
`define SCALE_HI          14
`define BIT_SEQ_SEL       14
`define BIT_VAL_ACCESS    7

`define MODE_NONE         3'h0
`define MODE_INPHASE      3'h4
`define MODE_QUAD         3'h6
`define MODE_TIED         3'h5

// Calibration phase lengths in ns at a 10 ns clock
`define CLK_PERIOD_NS     10
`define CAL_RESET_NS      200
`define CAL_TERM_NS       1000
`define CAL_LIN_NS        2000

`endif

// >>> src/trim_store.v
// Small memory holding one 16-bit calibration result per entry.
// Assumes one clock; read data is registered.
`timescale 1ns/100ps
module trim_store #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write port and registered read; contents undefined at power-on
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // trim_store

// >>> src/adc_ext_ctrl.v
// Extended-control register bank with its calibration sequencer and
// decoded mode outputs. Registers hold what the host writes; the
// decoded outputs apply them only in extended control mode.
// Assumes a host presenting one-cycle read and write strobes with a
// 4-bit address, synchronous to I_REF_CLK, and a calibration result
// word that is valid in the last linearity cycle.
// Assumes the antiphase bit comes from a register kept outside.
`timescale 1ns/100ps
`include "adc_ctrl_map.vh"
module adc_ext_ctrl #(
  parameter CAL_RESET_CYC = (`CAL_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter CAL_TERM_CYC  = (`CAL_TERM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter CAL_LIN_CYC   = (`CAL_LIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        I_REF_CLK,
  input  wire        I_RESET,
  input  wire        I_EXT_MODE,
  input  wire        I_DEMUX,
  input  wire        I_CAL_PIN,
  input  wire        I_PD_I_PIN,
  input  wire        I_PD_Q_PIN,
  input  wire        I_ANTIPHASE_BIT,
  input  wire        I_WR,
  input  wire        I_RD,
  input  wire [3:0]  I_ADDR,
  input  wire [15:0] I_WDATA,
  input  wire [15:0] I_CAL_RESULT,
  output reg  [15:0] O_RDATA,
  output reg         O_RVALID,
  output reg         O_CAL_BUSY,
  output reg         O_RESET_TRIMS,
  output reg         O_TERM_CAL,
  output reg         O_LIN_CAL,
  output reg         O_CLK_PHASE_90,
  output reg         O_CLK_FALLING,
  output reg         O_HIGH_SWING,
  output reg         O_PATTERN,
  output reg         O_INPHASE_POWER_DOWN,
  output reg         O_QUADRATURE_POWER_DOWN,
  output reg         O_SLOW_CLOCK,
  output reg         O_INPHASE_INTERLEAVE,
  output reg         O_QUADRATURE_INTERLEAVE,
  output reg         O_TIED_INTERLEAVE,
  output reg         O_ANTIPHASE_DUAL_EDGE,
  output reg         O_DUAL_EDGE_INPUT_Q,
  output reg         O_INPUT_TIE,
  output reg         O_SIGNED_FORMAT,
  output reg         O_STAMP_ENABLE,
  output reg         O_SINGLE_RATE,
  output reg         O_MODE_ILLEGAL,
  output reg         O_OFFSET_NEGATIVE,
  output reg  [11:0] O_OFFSET_SIZE,
  output reg  [14:0] O_RANGE_SCALE,
  output reg  [15:0] O_BIAS_TUNE
);
  // Sequencer phases; the full sequence walks all three,
  // the short one goes straight to linearity
  localparam ST_IDLE  = 2'h0;
  localparam ST_RESET = 2'h1;
  localparam ST_TERM  = 2'h2;
  localparam ST_LIN   = 2'h3;

  // Host-visible registers
  reg [15:0] main_cfg_reg;
  reg [15:0] rsvd_keep_reg;
  reg [15:0] offset_trim_reg;
  reg [15:0] scale_trim_reg;
  reg [15:0] seq_ctrl_reg;
  reg [15:0] bias_tune_reg;

  // Sequencer state and phase countdown
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;

  // Trigger edge memory
  reg        trig_prev_reg;
  reg        armed_reg;

  // Read pipeline
  reg        rd_pend_reg;
  reg        rd_mem_reg;
  reg [15:0] rd_hold_reg;

  // Trigger and sequencer nets
  wire        trig_now;
  wire        cal_start;
  wire        cal_done;

  // Host path into the store
  wire        host_val_wr;
  wire        mem_we;
  wire [15:0] mem_wdata;
  wire [15:0] mem_rdata;

  // Mode decode
  wire        ext;
  wire [2:0]  mode_bits;
  wire        mode_legal;

  // Pin and bit ORed; a start needs both low first, so rising edge only
  assign trig_now  = main_cfg_reg[`BIT_CAL_START] | I_CAL_PIN;
  // Triggers during a running calibration are dropped, not queued
  assign cal_start = trig_now & ~trig_prev_reg & armed_reg &
                     (state_reg == ST_IDLE);
  assign cal_done  = (state_reg == ST_LIN) && (cnt_reg == 16'h0000);

  // Host path to stored values only while access bit is set
  assign host_val_wr = I_WR & (I_ADDR == `ADDR_TRIM_VALUES) &
                       seq_ctrl_reg[`BIT_VAL_ACCESS];
  // Sequencer result wins over a host write landing the same cycle
  assign mem_we    = cal_done | host_val_wr;
  assign mem_wdata = cal_done ? I_CAL_RESULT : I_WDATA;

  // One word is enough here; a part with more trimmed elements would
  // widen DEPTH and steer the address from a scan position.
  // Read data is registered, hence the extra cycle on the read path.
  trim_store #(
    .WIDTH (16),
    .DEPTH (1),
    .AW    (1)
  ) u_store (
    .clk   (I_REF_CLK),
    .we    (mem_we),
    .waddr (1'b0),
    .wdata (mem_wdata),
    .raddr (1'b0),
    .rdata (mem_rdata)
  );

  // Register writes; trigger bit is never cleared by hardware
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      main_cfg_reg    <= `RST_MAIN_CFG;
      rsvd_keep_reg   <= `RST_RSVD_KEEP;
      offset_trim_reg <= `RST_OFFSET_TRIM;
      scale_trim_reg  <= `RST_SCALE_TRIM;
      seq_ctrl_reg    <= `RST_SEQ_CTRL;
      bias_tune_reg   <= `RST_BIAS_TUNE;
    end else if (I_WR) begin
      // Address 5 lives in the store; reserved words are kept as written
      // so a host that restores them reads back what it wrote
      case (I_ADDR)
        `ADDR_MAIN_CFG:    main_cfg_reg    <= I_WDATA;
        `ADDR_RSVD_KEEP:   rsvd_keep_reg   <= I_WDATA;
        `ADDR_OFFSET_TRIM: offset_trim_reg <= I_WDATA;
        `ADDR_SCALE_TRIM:  scale_trim_reg  <= I_WDATA;
        `ADDR_SEQ_CTRL:    seq_ctrl_reg    <= I_WDATA;
        `ADDR_BIAS_TUNE:   bias_tune_reg   <= I_WDATA;
        default: ;
      endcase
    end
  end

  // Edge memory; arming needs a low trigger seen after reset, so a
  // trigger already high at release cannot start a calibration
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      trig_prev_reg <= 1'b1;
      armed_reg     <= 1'b0;
    end else begin
      trig_prev_reg <= trig_now;
      if (!trig_now) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // Calibration sequencer next state; counters load length minus one
  // so each phase lasts exactly its parameter in cycles
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      // A start picks the full or the short sequence
      ST_IDLE: begin
        if (cal_start) begin
          if (seq_ctrl_reg[`BIT_SEQ_SEL]) begin
            state_next = ST_RESET;
            cnt_next   = CAL_RESET_CYC[15:0] - 16'h0001;
          end else begin
            state_next = ST_LIN;
            cnt_next   = CAL_LIN_CYC[15:0] - 16'h0001;
          end
        end
      end
      // Trimmed elements back to nominal
      ST_RESET: begin
        if (cnt_reg == 16'h0000) begin
          state_next = ST_TERM;
          cnt_next   = CAL_TERM_CYC[15:0] - 16'h0001;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      // Input termination trim
      ST_TERM: begin
        if (cnt_reg == 16'h0000) begin
          state_next = ST_LIN;
          cnt_next   = CAL_LIN_CYC[15:0] - 16'h0001;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      // Linearity trim; result is stored on its last cycle
      ST_LIN: begin
        if (cnt_reg == 16'h0000) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = 16'h0000;
      end
    endcase
  end

  // Sequencer state and phase strobes; taken from the next state so
  // busy and the phase levels change on the same edge
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 16'h0000;
      O_CAL_BUSY    <= 1'b0;
      O_RESET_TRIMS <= 1'b0;
      O_TERM_CAL    <= 1'b0;
      O_LIN_CAL     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      O_CAL_BUSY    <= (state_next != ST_IDLE);
      O_RESET_TRIMS <= (state_next == ST_RESET);
      O_TERM_CAL    <= (state_next == ST_TERM);
      O_LIN_CAL     <= (state_next == ST_LIN);
    end
  end

  // Read path; the memory word comes one cycle late so answers take two
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      rd_pend_reg <= 1'b0;
      rd_mem_reg  <= 1'b0;
      rd_hold_reg <= 16'h0000;
      O_RDATA     <= 16'h0000;
      O_RVALID    <= 1'b0;
    end else begin
      // Address and access bit are captured with the strobe, so a
      // write in the next cycle does not change the answer
      rd_pend_reg <= I_RD;
      rd_mem_reg  <= (I_ADDR == `ADDR_TRIM_VALUES) & seq_ctrl_reg[`BIT_VAL_ACCESS];
      case (I_ADDR)
        `ADDR_MAIN_CFG:    rd_hold_reg <= main_cfg_reg;
        `ADDR_RSVD_KEEP:   rd_hold_reg <= rsvd_keep_reg;
        `ADDR_OFFSET_TRIM: rd_hold_reg <= offset_trim_reg;
        `ADDR_SCALE_TRIM:  rd_hold_reg <= scale_trim_reg;
        `ADDR_SEQ_CTRL:    rd_hold_reg <= seq_ctrl_reg;
        `ADDR_BIAS_TUNE:   rd_hold_reg <= bias_tune_reg;
        default:           rd_hold_reg <= 16'h0000;
      endcase
      // Data holds between answers; valid is a one-cycle pulse
      O_RVALID <= rd_pend_reg;
      if (rd_pend_reg) begin
        O_RDATA <= rd_mem_reg ? mem_rdata : rd_hold_reg;
      end
    end
  end

  // Settings act only in extended mode; pin mode sees power-on defaults
  // Reserved bits are stored but drive nothing
  assign ext        = I_EXT_MODE;
  assign mode_bits  = main_cfg_reg[`MODE_HI:`MODE_LO];
  assign mode_legal = (mode_bits == `MODE_NONE) || (mode_bits == `MODE_INPHASE) ||
                      (mode_bits == `MODE_QUAD) || (mode_bits == `MODE_TIED);

  // Decoded controls, all registered; reset values equal the pin-mode
  // values, so leaving reset in pin mode shows no extra transition
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_CLK_PHASE_90          <= 1'b0;
      O_CLK_FALLING           <= 1'b0;
      O_HIGH_SWING            <= 1'b1;
      O_PATTERN               <= 1'b0;
      O_INPHASE_POWER_DOWN    <= 1'b0;
      O_QUADRATURE_POWER_DOWN <= 1'b0;
      O_SLOW_CLOCK            <= 1'b0;
      O_INPHASE_INTERLEAVE    <= 1'b0;
      O_QUADRATURE_INTERLEAVE <= 1'b0;
      O_TIED_INTERLEAVE       <= 1'b0;
      O_ANTIPHASE_DUAL_EDGE   <= 1'b0;
      O_DUAL_EDGE_INPUT_Q     <= 1'b0;
      O_INPUT_TIE             <= 1'b0;
      O_SIGNED_FORMAT         <= 1'b0;
      O_STAMP_ENABLE          <= 1'b0;
      O_SINGLE_RATE           <= 1'b0;
      O_MODE_ILLEGAL          <= 1'b0;
      O_OFFSET_NEGATIVE       <= 1'b0;
      O_OFFSET_SIZE           <= `RST_OFFSET_FIELD;
      O_RANGE_SCALE           <= `RST_SCALE_FIELD;
      O_BIAS_TUNE             <= `RST_BIAS_TUNE;
    end else begin
      // Non-demux forces 0 degree double rate whatever the bits say
      O_SINGLE_RATE  <= ext & I_DEMUX & main_cfg_reg[`BIT_SINGLE_RATE];
      O_CLK_PHASE_90 <= ext & I_DEMUX & ~main_cfg_reg[`BIT_SINGLE_RATE] &
                        main_cfg_reg[`BIT_CLK_PHASE];
      O_CLK_FALLING  <= ext & I_DEMUX & main_cfg_reg[`BIT_SINGLE_RATE] &
                        main_cfg_reg[`BIT_CLK_PHASE];

      O_HIGH_SWING   <= ext ? main_cfg_reg[`BIT_SWING] : 1'b1;
      O_PATTERN      <= ext & main_cfg_reg[`BIT_PATTERN];

      // Pins stay live in either mode
      O_INPHASE_POWER_DOWN    <= I_PD_I_PIN | (ext & main_cfg_reg[`BIT_PD_I]);
      O_QUADRATURE_POWER_DOWN <= I_PD_Q_PIN | (ext & main_cfg_reg[`BIT_PD_Q]);
      O_SLOW_CLOCK   <= ext & main_cfg_reg[`BIT_SLOW_CLK];

      // Illegal mode codes fall back to non-interleaved
      O_INPHASE_INTERLEAVE    <= ext & (mode_bits == `MODE_INPHASE);
      O_QUADRATURE_INTERLEAVE <= ext & (mode_bits == `MODE_QUAD);
      O_TIED_INTERLEAVE       <= ext & (mode_bits == `MODE_TIED);
      O_ANTIPHASE_DUAL_EDGE   <= ext & (mode_bits == `MODE_NONE) & I_ANTIPHASE_BIT;
      O_DUAL_EDGE_INPUT_Q <= ext & mode_legal & main_cfg_reg[`BIT_DE_ENABLE] &
                             main_cfg_reg[`BIT_DE_INPUT];
      O_INPUT_TIE         <= ext & mode_legal & main_cfg_reg[`BIT_DE_ENABLE] &
                             main_cfg_reg[`BIT_DE_TIE];
      O_MODE_ILLEGAL      <= ext & ~mode_legal;
      O_SIGNED_FORMAT <= ext & main_cfg_reg[`BIT_SIGNED];
      O_STAMP_ENABLE  <= ext & main_cfg_reg[`BIT_STAMP];
      O_OFFSET_NEGATIVE <= ext & offset_trim_reg[`BIT_OFS_POL];

      // Trims pass straight through; reserved upper bits are dropped
      O_OFFSET_SIZE     <= ext ? offset_trim_reg[`OFS_SIZE_HI:0] : `RST_OFFSET_FIELD;
      O_RANGE_SCALE     <= ext ? scale_trim_reg[`SCALE_HI:0] : `RST_SCALE_FIELD;
      O_BIAS_TUNE       <= ext ? bias_tune_reg : `RST_BIAS_TUNE;
    end
  end
endmodule // adc_ext_ctrl

// >>> sim/adc_ext_ctrl_props.sv
// Checker for the control register bank: read timing, calibration phases.
// Assumes binding to the bank; sees only its ports.
`timescale 1ns/100ps
module adc_ext_ctrl_props #(
  parameter CAL_RESET_CYC = 20,
  parameter CAL_TERM_CYC  = 100,
  parameter CAL_LIN_CYC   = 200
) (
  input wire        I_REF_CLK,
  input wire        I_RESET,
  input wire        I_EXT_MODE,
  input wire        I_PD_I_PIN,
  input wire        I_RD,
  input wire [3:0]  I_ADDR,
  input wire [15:0] O_RDATA,
  input wire        O_RVALID,
  input wire        O_CAL_BUSY,
  input wire        O_RESET_TRIMS,
  input wire        O_TERM_CAL,
  input wire        O_LIN_CAL,
  input wire        O_INPHASE_POWER_DOWN,
  input wire        O_PATTERN,
  input wire        O_HIGH_SWING
);
  localparam int FULL = CAL_RESET_CYC + CAL_TERM_CYC + CAL_LIN_CYC;
  reg [15:0] busy_cnt_reg;
  // Busy length in a counter, not a long repetition
  always @(posedge I_REF_CLK) begin
    if (I_RESET || !O_CAL_BUSY)
      busy_cnt_reg <= 16'h0000;
    else
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  a_read_answer_time: assert property (I_RD |-> ##2 O_RVALID)
    else $error("read answer late");
  a_rvalid_cause: assert property (O_RVALID |-> $past(I_RD, 2))
    else $error("answer without read");
  a_unmapped_zero: assert property (I_RD && I_ADDR[3] |-> ##2 O_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_pd_pin_acts: assert property (I_PD_I_PIN |-> ##[1:2] O_INPHASE_POWER_DOWN)
    else $error("power-down pin ignored");
  a_pin_mode_defaults: assert property ((!I_EXT_MODE)[*3] |-> !O_PATTERN && O_HIGH_SWING)
    else $error("pin mode shows register values");
  a_phase_matches_busy: assert property (
    $countones({O_RESET_TRIMS, O_TERM_CAL, O_LIN_CAL}) == O_CAL_BUSY)
    else $error("phase outputs disagree with busy");
  a_reset_then_term: assert property ($fell(O_RESET_TRIMS) && O_CAL_BUSY |-> O_TERM_CAL)
    else $error("termination phase skipped");
  a_term_then_lin: assert property ($fell(O_TERM_CAL) && O_CAL_BUSY |-> O_LIN_CAL)
    else $error("linearity phase skipped");
  a_cal_length: assert property (
    $fell(O_CAL_BUSY) && !$past(I_RESET) |-> busy_cnt_reg == FULL || busy_cnt_reg == CAL_LIN_CYC)
    else $error("calibration length wrong");
  c_full_cal: cover property ($fell(O_CAL_BUSY) && busy_cnt_reg == FULL);
  c_short_cal: cover property ($fell(O_CAL_BUSY) && busy_cnt_reg == CAL_LIN_CYC);
  c_unmapped_read: cover property (I_RD && I_ADDR[3]);
endmodule // adc_ext_ctrl_props

// >>> sim/host_model.sv
// Host model: register strobes and calibration pin.
// Assumes the bank answers reads two edges after the strobe.
`timescale 1ns/100ps
module host_model (
  input  wire        clk,
  input  wire [15:0] rdata,
  input  wire        rvalid,
  output reg         wr,
  output reg         rd,
  output reg  [3:0]  addr,
  output reg  [15:0] wdata,
  output reg         cal_pin
);
  initial begin
    {wr, rd, addr, wdata, cal_pin} = 23'h000000;
  end
  // Data lines show the inverse afterwards, so stale data never passes
  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk) #1;
      {wr, addr, wdata} = {1'b1, a, d};
      @(posedge clk) #1;
      {wr, wdata} = {1'b0, ~d};
    end
  endtask
  // Bounded wait for the answer pulse
  task rd_reg(input [3:0] a, output [15:0] d, output ok);
    integer n;
    begin
      @(posedge clk) #1;
      {rd, addr} = {1'b1, a};
      @(posedge clk) #1;
      {rd, ok, d} = 18'h00000;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        @(posedge clk) #1;
        if (rvalid === 1'b1)
          {ok, d} = {1'b1, rdata};
      end
    end
  endtask
  // Pin is ORed with the start bit; caller keeps both low first
  task set_cal(input v);
    begin
      cal_pin = v;
    end
  endtask
endmodule // host_model

// >>> sim/tb_adc_ext_ctrl.sv
// Self-checking bench for the control register bank against a register model.
// Assumes short calibration phases set through the bank's parameters.
`timescale 1ns/100ps
module tb_adc_ext_ctrl;
  localparam R = 2, T = 3, L = 4;
  localparam [17:0] MODES = {3'h0, 3'h7, 3'h5, 3'h6, 3'h4, 3'h0};
  reg         I_REF_CLK = 1'b0;
  reg         I_RESET = 1'b1;
  reg         I_EXT_MODE = 1'b1;
  reg         I_DEMUX = 1'b1;
  reg         I_PD_I_PIN = 1'b0;
  reg         I_PD_Q_PIN = 1'b0;
  reg         I_ANTIPHASE_BIT = 1'b0;
  reg  [15:0] I_CAL_RESULT = 16'h0000;
  wire        I_WR, I_RD, I_CAL_PIN, O_RVALID, O_CAL_BUSY;
  wire [3:0]  I_ADDR;
  wire [15:0] I_WDATA, O_RDATA;
  wire [60:0] obs;
  reg  [15:0] m [0:6];
  reg  [15:0] rv;
  reg  [31:0] r;
  reg         ok;
  integer     seed, mismatches, checked, i, a;
  always #5 I_REF_CLK = ~I_REF_CLK;
  host_model host_model_i (.clk(I_REF_CLK), .rdata(O_RDATA), .rvalid(O_RVALID), .wr(I_WR),
    .rd(I_RD), .addr(I_ADDR), .wdata(I_WDATA), .cal_pin(I_CAL_PIN));
  adc_ext_ctrl #(.CAL_RESET_CYC(R), .CAL_TERM_CYC(T), .CAL_LIN_CYC(L)) adc_ext_ctrl_i (
    .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_EXT_MODE(I_EXT_MODE), .I_DEMUX(I_DEMUX),
    .I_CAL_PIN(I_CAL_PIN), .I_PD_I_PIN(I_PD_I_PIN), .I_PD_Q_PIN(I_PD_Q_PIN),
    .I_ANTIPHASE_BIT(I_ANTIPHASE_BIT), .I_WR(I_WR), .I_RD(I_RD), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_CAL_RESULT(I_CAL_RESULT), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
    .O_CAL_BUSY(O_CAL_BUSY), .O_RESET_TRIMS(), .O_TERM_CAL(), .O_LIN_CAL(),
    .O_CLK_PHASE_90(obs[60]), .O_CLK_FALLING(obs[59]), .O_HIGH_SWING(obs[58]),
    .O_PATTERN(obs[57]), .O_INPHASE_POWER_DOWN(obs[56]), .O_QUADRATURE_POWER_DOWN(obs[55]),
    .O_SLOW_CLOCK(obs[54]), .O_INPHASE_INTERLEAVE(obs[53]), .O_QUADRATURE_INTERLEAVE(obs[52]),
    .O_TIED_INTERLEAVE(obs[51]), .O_ANTIPHASE_DUAL_EDGE(obs[50]), .O_DUAL_EDGE_INPUT_Q(obs[49]),
    .O_INPUT_TIE(obs[48]), .O_SIGNED_FORMAT(obs[47]), .O_STAMP_ENABLE(obs[46]),
    .O_SINGLE_RATE(obs[45]), .O_MODE_ILLEGAL(obs[44]), .O_OFFSET_NEGATIVE(obs[43]),
    .O_OFFSET_SIZE(obs[42:31]), .O_RANGE_SCALE(obs[30:16]), .O_BIAS_TUNE(obs[15:0]));
  // Reference decode; pin mode shows power-on values, power-down pins always act
  function [60:0] expect_obs;
    reg [15:0] c;
    reg [2:0]  d;
    reg        s;
    begin
      c = I_EXT_MODE ? m[0] : 16'h2000;
      d = c[7:5];
      s = I_DEMUX & c[2];
      expect_obs = {I_DEMUX & ~s & c[14], s & c[14], c[13:12], c[11] | I_PD_I_PIN,
        c[10] | I_PD_Q_PIN, c[8], d == 3'h4, d == 3'h6, d == 3'h5,
        I_EXT_MODE & I_ANTIPHASE_BIT & (d == 3'h0), d == 3'h6, d == 3'h5, c[4:3], s,
        !(d == 3'h0 || d[2:1] == 2'b10 || d == 3'h6),
        I_EXT_MODE ? {m[2][12:0], m[3][14:0], m[6]} : {13'h0000, 15'h4000, 16'h1C2E}};
    end
  endfunction
  task summarize;
    begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk_reg(input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  task chk_out(input [60:0] e, input [60:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  // Model update mirrors the refusals of the bank
  task w(input [3:0] ad, input [15:0] d);
    begin
      host_model_i.wr_reg(ad, d);
      if (ad < 4'h7 && (ad != 4'h5 || m[4][7]))
        m[ad] = d;
    end
  endtask
  task rd_chk(input [3:0] ad);
    begin
      host_model_i.rd_reg(ad, rv, ok);
      if (ok !== 1'b1) begin
        mismatches = mismatches + 1;
        summarize;
      end
      chk_reg((ad < 4'h7 && (ad != 4'h5 || m[4][7])) ? m[ad] : 16'h0000, rv);
    end
  endtask
  // Three edges: enough for decoded outputs to follow
  task settle;
    begin
      repeat (3) @(posedge I_REF_CLK);
      #1;
    end
  endtask
  // Length of the busy level; zero when no start is expected
  task cal_wait(input integer n);
    integer k;
    begin
      for (k = 0; O_CAL_BUSY !== 1'b1 && k < 8; k = k + 1)
        @(posedge I_REF_CLK) #1;
      if (k < 8) begin
        for (k = 0; O_CAL_BUSY === 1'b1 && k < 600; k = k + 1)
          @(posedge I_REF_CLK) #1;
      end else
        k = 0;
      chk_reg(n[15:0], k[15:0]);
      if (k == 600)
        summarize;
    end
  endtask
  initial begin
    {seed, mismatches, checked} = {32'd67869, 32'd0, 32'd0};
    {m[0], m[1], m[2], m[3]} = {16'h2000, 16'h2907, 16'h0000, 16'h4000};
    {m[4], m[5], m[6]} = {16'h0B4B, 16'hXXXX, 16'h1C2E};
    repeat (3) @(posedge I_REF_CLK);
    #1 I_RESET = 1'b0;
    for (a = 0; a < 16; a = a + 1)
      rd_chk(a[3:0]);
    chk_out(expect_obs(), obs);
    // Every legal mode, one illegal code, then antiphase
    for (i = 0; i < 6; i = i + 1) begin
      I_ANTIPHASE_BIT = (i == 5);
      r = $random(seed);
      w(4'h0, (r[15:0] & 16'h7D1C) | {8'h00, MODES[3*i +: 3], 5'h00});
      w(4'h2, r[31:16] & 16'h1FFF);
      r = $random(seed);
      w(4'h3, (r[15:0] & 16'h7FFF) | 16'h4000);
      w(4'h6, r[31:16]);
      settle;
      chk_out(expect_obs(), obs);
      for (a = 0; a < 7; a = a + 1)
        rd_chk(a[3:0]);
    end
    w(4'h0, 16'h6004);
    settle;
    chk_out(expect_obs(), obs);
    I_DEMUX = 1'b0;
    settle;
    chk_out(expect_obs(), obs);
    {I_DEMUX, I_EXT_MODE, I_PD_I_PIN, I_PD_Q_PIN} = 4'h B;
    settle;
    chk_out(expect_obs(), obs);
    {I_EXT_MODE, I_PD_I_PIN, I_PD_Q_PIN} = 3'h4;
    w(4'h1, 16'h2907);
    w(4'h6, 16'h1C0E);
    rd_chk(4'h6);
    // Full sequence first, then toggle rule, then short sequence by the pin
    I_CAL_RESULT = r[15:0];
    w(4'h4, 16'h4BCB);
    w(4'h0, 16'hA000);
    cal_wait(R + T + L);
    m[5] = I_CAL_RESULT;
    rd_chk(4'h5);
    w(4'h0, 16'hA000);
    cal_wait(0);
    w(4'h0, 16'h2000);
    w(4'h4, 16'h0BCB);
    I_CAL_RESULT = ~r[15:0];
    host_model_i.set_cal(1'b1);
    cal_wait(L);
    m[5] = I_CAL_RESULT;
    rd_chk(4'h5);
    w(4'h0, 16'hA000);
    cal_wait(0);
    host_model_i.set_cal(1'b0);
    w(4'h5, 16'h5A3C);
    rd_chk(4'h5);
    w(4'h4, 16'h0B4B);
    w(4'h5, 16'hC3A5);
    rd_chk(4'h5);
    w(4'h4, 16'h0BCB);
    rd_chk(4'h5);
    w(4'h9, 16'hFFFF);
    rd_chk(4'h9);
    summarize;
  end
endmodule // tb_adc_ext_ctrl

bind adc_ext_ctrl adc_ext_ctrl_props #(.CAL_RESET_CYC(CAL_RESET_CYC),
  .CAL_TERM_CYC(CAL_TERM_CYC), .CAL_LIN_CYC(CAL_LIN_CYC)) props_i (
  .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_EXT_MODE(I_EXT_MODE), .I_PD_I_PIN(I_PD_I_PIN),
  .I_RD(I_RD), .I_ADDR(I_ADDR), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .O_CAL_BUSY(O_CAL_BUSY), .O_RESET_TRIMS(O_RESET_TRIMS), .O_TERM_CAL(O_TERM_CAL),
  .O_LIN_CAL(O_LIN_CAL), .O_INPHASE_POWER_DOWN(O_INPHASE_POWER_DOWN),
  .O_PATTERN(O_PATTERN), .O_HIGH_SWING(O_HIGH_SWING));
